//--- pkg/mps_pkg.sv
package mps_pkg;
  // Register indices; the APB byte address is four times the index.
  localparam logic [13:0] IDX_OCU  = 14'h0066;
  localparam logic [13:0] IDX_OCL  = 14'h0067;
  localparam logic [13:0] IDX_ICU  = 14'h0068;
  localparam logic [13:0] IDX_ICL  = 14'h0069;
  localparam logic [13:0] IDX_NCC  = 14'h006A;
  localparam logic [13:0] IDX_INL  = 14'h006B;
  localparam logic [13:0] IDX_TCS  = 14'h006C;
  localparam logic [13:0] IDX_ODR  = 14'h006D;
  localparam logic [13:0] IDX_CPC  = 14'h006E;
  localparam logic [13:0] IDX_TMB  = 14'h006F;
  localparam logic [13:0] IDX_BUF0 = 14'h0FC4;
  localparam logic [13:0] IDX_BUFN = 14'h0FD3;
  localparam int          NBUF     = 16;
  // Output control upper bits.
  localparam int OCU_SDEN = 0;
  localparam int OCU_WRITE_TIMING_IRQ_FLAG = 1;
  localparam int OCU_SHUTDOWN_IRQ_FLAG = 2;
  localparam int OCU_SDFE = 3;
  localparam int OCU_OPS  = 4;
  localparam int OCU_FRC  = 7;
  // Output control lower, input control upper bits.
  localparam int OCL_POSITION_DETECT_IRQ_FLAG = 0;
  localparam int OCL_SEQE = 1;
  localparam int ICU_COMPARE_MATCH_IRQ_FLAG = 2;
  // Timer control status bits.
  localparam int TCS_TIMER_COUNT_ENABLE = 0;
  localparam int TCS_CLK  = 1;
  localparam int TCS_MODE = 4;
  localparam int TCS_COMPARE_CLEAR_IRQ_ENABLE = 5;
  localparam int TCS_COMPARE_CLEAR_IRQ_FLAG = 6;
  localparam int TCS_TCLR = 7;
  // Transfer methods and edge synchronisation codes.
  localparam logic [2:0] OPS_BUF0  = 3'h0;
  localparam logic [2:0] OPS_UFL   = 3'h2;
  localparam logic [2:0] OPS_PDU_A = 3'h3;
  localparam logic [2:0] OPS_PDU_B = 3'h7;
  localparam logic [1:0] ES_OFF  = 2'h0;
  localparam logic [1:0] ES_RISE = 2'h1;
  localparam logic [1:0] ES_FALL = 2'h2;
  localparam logic [3:0] STRB_WORD = 4'h3;
  localparam logic [7:0] RST_BYTE  = 8'h00;
  localparam logic [15:0] RST_WORD = 16'h0000;
  localparam logic [5:0] FILT_BASE = 6'h04;
  localparam logic [5:0] SENSE_LEN = 6'h04;

  typedef enum logic [1:0] {SD_IDLE, SD_FILT, SD_TRIP} mps_sd_e;

  typedef struct packed {
    logic shutdown_irq_flag;
    logic write_timing_irq_flag;
    logic position_detect_irq_flag;
    logic compare_match_irq_flag;
    logic compare_clear_irq_flag;
  } mps_flags_s;
endpackage

//--- src/mps_sequencer.sv
// Local design decision: the APB slave port.
`timescale 1ns/1ns
// Contract
// - After method change, bank/address pick source.
// - Buffer-zero method ignores bank and address.
// - Buffer-zero method: only word write transfers.
// - Shutdown detector works only on running clock.
// - Recognised shutdown forces outputs within two cycles.
// - Interrupt held while any flag other than compare clear reads one.
// - Each interrupt cause readable as own flag.
// - Equal compare load gives no immediate match.
// - Compare clear flag with enable holds interrupt.
// - Enabled sequencer owns shared output pin.
// - Enabled sequencer takes PWM and reload timer.
// - Shutdown low forces inactive levels, sets flag.
// - Shutdown filter delays 4, 8, 16, 32 clocks.
// - Timer match clears count, sets clear flag.
module mps_sequencer (
  input  wire logic        clk,
  input  wire logic        arst_n,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [15:0] paddr,
  input  wire logic [31:0] pwdata,
  input  wire logic [3:0]  pstrb,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        shutdown_input,
  input  wire logic [2:0]  position_sense_input,
  input  wire logic        pwm_level,
  input  wire logic        reload_underflow,
  output logic      [5:0]  waveform_output,
  output logic             irq,
  output logic             pin_owner,
  output logic             pwm_free,
  output logic             reload_free
);
  function automatic logic [5:0] filt_len(input logic [1:0] sel);
    filt_len = mps_pkg::FILT_BASE << sel;
  endfunction

  logic [7:0]  ocu_ff, ocl_ff, icu_ff, icl_ff, ncc_ff, inl_ff, tcs_ff;
  logic [15:0] odr_ff, cpc_ff, tmb_ff, cnt_ff;
  logic [15:0] buf_mem [mps_pkg::NBUF];
  logic [31:0] rdata_ff;
  logic        ready_ff, err_ff, irq_ff, owner_ff, pwmf_ff, relf_ff;
  logic [5:0]  wave_ff;
  logic [1:0]  sd_sync_ff;
  logic [5:0]  sd_cnt_ff;
  mps_pkg::mps_sd_e sd_state_ff;
  logic        pwm_d_ff, pd_arm_ff, armed_ff, timer_count_enable_d_ff;
  logic [6:0]  pre_ff;

  wire [13:0] idx    = paddr[15:2];
  wire        acc    = psel & penable & ready_ff;
  wire        wr     = acc & pwrite;
  wire        buf_hit = idx >= mps_pkg::IDX_BUF0 && idx <= mps_pkg::IDX_BUFN;
  wire [3:0]  buf_idx = 4'(idx - mps_pkg::IDX_BUF0);
  wire        mapped = buf_hit || (idx >= mps_pkg::IDX_OCU &&
                                   idx <= mps_pkg::IDX_TMB);
  wire w_ocu = wr && idx == mps_pkg::IDX_OCU;
  wire w_ocl = wr && idx == mps_pkg::IDX_OCL;
  wire w_icu = wr && idx == mps_pkg::IDX_ICU;
  wire w_icl = wr && idx == mps_pkg::IDX_ICL;
  wire w_ncc = wr && idx == mps_pkg::IDX_NCC;
  wire w_inl = wr && idx == mps_pkg::IDX_INL;
  wire w_tcs = wr && idx == mps_pkg::IDX_TCS;
  wire w_odr = wr && idx == mps_pkg::IDX_ODR;
  wire w_cpc = wr && idx == mps_pkg::IDX_CPC;
  wire w_buf = wr && buf_hit;
  wire [7:0] wb0 = pwdata[7:0];

  wire [2:0] ops      = ocu_ff[mps_pkg::OCU_OPS +: 3];
  wire       seq_en   = ocl_ff[mps_pkg::OCL_SEQE];
  wire       sd_en    = ocu_ff[mps_pkg::OCU_SDEN];
  wire [1:0] edge_sel = icu_ff[1:0];
  wire       sd_low   = ~sd_sync_ff[1];
  wire       sd_trip  = sd_state_ff == mps_pkg::SD_TRIP;

  // Sense filters: a new level is accepted after it stays put long enough.
  logic [2:0] sense_f;
  logic [2:0] sense_chg;
  genvar g;
  generate
    for (g = 0; g < 3; g++)
    begin : g_sense
      logic [1:0] sy_ff;
      logic [5:0] c_ff;
      logic       f_ff;
      wire  [5:0] len = icl_ff[g] ? filt_len(ncc_ff[2+2*g +: 2]) : 6'h01;
      always_ff @(posedge clk or negedge arst_n)
      begin
        if (!arst_n)
        begin
          sy_ff <= 2'h0;
          c_ff  <= 6'h00;
          f_ff  <= 1'b0;
        end
        else
        begin
          sy_ff <= {sy_ff[0], position_sense_input[g]};
          c_ff  <= (sy_ff[1] == f_ff || c_ff + 6'h01 >= len) ? 6'h00
                   : c_ff + 6'h01;
          if (sy_ff[1] != f_ff && c_ff + 6'h01 >= len)
            f_ff <= sy_ff[1];
        end
      end
      assign sense_f[g]   = f_ff;
      assign sense_chg[g] = sy_ff[1] != f_ff && c_ff + 6'h01 >= len;
    end
  endgenerate
  wire pd_evt = |sense_chg;

  // Transfer triggers per method.
  wire pwm_edge = edge_sel == mps_pkg::ES_RISE ? pwm_level & ~pwm_d_ff
                : edge_sel == mps_pkg::ES_FALL ? ~pwm_level & pwm_d_ff
                : 1'b0;
  wire buf0_wr  = w_buf && buf_idx == 4'h0;
  wire m_buf0   = ops == mps_pkg::OPS_BUF0;
  wire m_pdu    = ops == mps_pkg::OPS_PDU_A || ops == mps_pkg::OPS_PDU_B;
  wire xfer_go  = m_buf0 ? buf0_wr && pstrb == mps_pkg::STRB_WORD
                : ops == mps_pkg::OPS_UFL ? reload_underflow
                : m_pdu ? reload_underflow & pd_arm_ff
                : pwm_edge;
  // Source is buffer zero, or the bank and address held in output data.
  wire [3:0]  src_idx = m_buf0 ? 4'h0 : odr_ff[11:8];
  wire [15:0] src_val = m_buf0 ? pwdata[15:0] : buf_mem[src_idx];

  // Timer: prescaled tick, compare clear, capture on restart.
  wire       timer_count_enable    = tcs_ff[mps_pkg::TCS_TIMER_COUNT_ENABLE];
  wire [6:0] pre_top = 7'(7'h01 << tcs_ff[mps_pkg::TCS_CLK +: 3]) - 7'h01;
  wire       tick    = timer_count_enable && pre_ff >= pre_top;
  wire       cmp_hit = tick && armed_ff && cnt_ff == cpc_ff;
  wire       cpc_eq  = w_cpc && pwdata[15:0] == cnt_ff;
  wire       tclr    = w_tcs && pwdata[mps_pkg::TCS_TCLR];
  wire       t_clr   = cmp_hit || tclr || (tcs_ff[mps_pkg::TCS_MODE]
                       ? pd_evt : xfer_go);

  mps_pkg::mps_flags_s set_f, flg;
  assign set_f.shutdown_irq_flag = sd_trip & sd_en;
  assign set_f.write_timing_irq_flag = xfer_go;
  assign set_f.position_detect_irq_flag = pd_evt;
  assign set_f.compare_match_irq_flag = cmp_hit;
  assign set_f.compare_clear_irq_flag = cmp_hit;
  assign flg.shutdown_irq_flag = ocu_ff[mps_pkg::OCU_SHUTDOWN_IRQ_FLAG];
  assign flg.write_timing_irq_flag = ocu_ff[mps_pkg::OCU_WRITE_TIMING_IRQ_FLAG];
  assign flg.position_detect_irq_flag = ocl_ff[mps_pkg::OCL_POSITION_DETECT_IRQ_FLAG];
  assign flg.compare_match_irq_flag = icu_ff[mps_pkg::ICU_COMPARE_MATCH_IRQ_FLAG];
  assign flg.compare_clear_irq_flag = tcs_ff[mps_pkg::TCS_COMPARE_CLEAR_IRQ_FLAG];

  // Flags: a write of zero clears, a hardware set in the same cycle wins.
  wire nxt_shutdown_irq_flag = (flg.shutdown_irq_flag & ~(w_ocu & ~wb0[mps_pkg::OCU_SHUTDOWN_IRQ_FLAG]))
                  | set_f.shutdown_irq_flag;
  wire nxt_write_timing_irq_flag = (flg.write_timing_irq_flag & ~(w_ocu & ~wb0[mps_pkg::OCU_WRITE_TIMING_IRQ_FLAG]))
                  | set_f.write_timing_irq_flag;
  wire nxt_position_detect_irq_flag = (flg.position_detect_irq_flag & ~(w_ocl & ~wb0[mps_pkg::OCL_POSITION_DETECT_IRQ_FLAG]))
                  | set_f.position_detect_irq_flag;
  wire nxt_compare_match_irq_flag = (flg.compare_match_irq_flag & ~(w_icu & ~wb0[mps_pkg::ICU_COMPARE_MATCH_IRQ_FLAG]))
                  | set_f.compare_match_irq_flag;
  wire nxt_compare_clear_irq_flag = (flg.compare_clear_irq_flag & ~(w_tcs & ~wb0[mps_pkg::TCS_COMPARE_CLEAR_IRQ_FLAG]))
                  | set_f.compare_clear_irq_flag;
  // The request follows the enable as it will stand after this edge.
  wire nxt_compare_clear_irq_enable = w_tcs ? wb0[mps_pkg::TCS_COMPARE_CLEAR_IRQ_ENABLE] : tcs_ff[mps_pkg::TCS_COMPARE_CLEAR_IRQ_ENABLE];

  wire [31:0] nxt_rdata =
      buf_hit ? {16'h0000, buf_mem[buf_idx]}
    : idx == mps_pkg::IDX_OCU ? {24'h0, ocu_ff[7:1] & 7'h7F,
                                 ocu_ff[0]} | {24'h0, sd_trip & sd_en, 7'h0}
    : idx == mps_pkg::IDX_OCL ? {24'h0, ocl_ff}
    : idx == mps_pkg::IDX_ICU ? {24'h0, icu_ff}
    : idx == mps_pkg::IDX_ICL ? {24'h0, icl_ff}
    : idx == mps_pkg::IDX_NCC ? {24'h0, ncc_ff}
    : idx == mps_pkg::IDX_INL ? {24'h0, inl_ff}
    : idx == mps_pkg::IDX_TCS ? {24'h0, tcs_ff}
    : idx == mps_pkg::IDX_ODR ? {16'h0, odr_ff}
    : idx == mps_pkg::IDX_CPC ? {16'h0, cpc_ff}
    : idx == mps_pkg::IDX_TMB ? {16'h0, tmb_ff}
    : 32'h0;

  // Shutdown recognition; the detector only advances while clk runs.
  wire [5:0] sd_len = filt_len(ncc_ff[1:0]);
  mps_pkg::mps_sd_e nxt_sd;
  assign nxt_sd = !sd_low ? mps_pkg::SD_IDLE
    : sd_trip ? mps_pkg::SD_TRIP
    : !ocu_ff[mps_pkg::OCU_SDFE] ? mps_pkg::SD_TRIP
    : sd_cnt_ff + 6'h01 >= sd_len ? mps_pkg::SD_TRIP
    : mps_pkg::SD_FILT;

  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      sd_sync_ff  <= 2'h3;
      sd_state_ff <= mps_pkg::SD_IDLE;
      sd_cnt_ff   <= 6'h00;
    end
    else
    begin
      sd_sync_ff  <= {sd_sync_ff[0], shutdown_input};
      sd_state_ff <= nxt_sd;
      sd_cnt_ff   <= nxt_sd == mps_pkg::SD_FILT ? sd_cnt_ff + 6'h01 : 6'h00;
    end
  end

  // Control registers; reset clears flags, sense sync, shutdown state and filters; shutdown sync resets high.
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      ocu_ff <= mps_pkg::RST_BYTE;
      ocl_ff <= mps_pkg::RST_BYTE;
      icu_ff <= mps_pkg::RST_BYTE;
      icl_ff <= mps_pkg::RST_BYTE;
      ncc_ff <= mps_pkg::RST_BYTE;
      inl_ff <= mps_pkg::RST_BYTE;
      tcs_ff <= mps_pkg::RST_BYTE;
    end
    else
    begin
      if (w_ocu)
      begin
        ocu_ff[mps_pkg::OCU_SDEN] <= wb0[mps_pkg::OCU_SDEN];
        ocu_ff[mps_pkg::OCU_SDFE] <= wb0[mps_pkg::OCU_SDFE];
        ocu_ff[mps_pkg::OCU_OPS +: 3] <= wb0[mps_pkg::OCU_OPS +: 3];
      end
      ocu_ff[mps_pkg::OCU_SHUTDOWN_IRQ_FLAG] <= nxt_shutdown_irq_flag;
      ocu_ff[mps_pkg::OCU_WRITE_TIMING_IRQ_FLAG] <= nxt_write_timing_irq_flag;
      if (w_ocl)
        ocl_ff[7:1] <= wb0[7:1];
      ocl_ff[mps_pkg::OCL_POSITION_DETECT_IRQ_FLAG] <= nxt_position_detect_irq_flag;
      if (w_icu)
        icu_ff[1:0] <= wb0[1:0];
      icu_ff[mps_pkg::ICU_COMPARE_MATCH_IRQ_FLAG] <= nxt_compare_match_irq_flag;
      if (w_icl)
        icl_ff <= wb0 & 8'h07;
      if (w_ncc)
        ncc_ff <= wb0;
      if (w_inl)
        inl_ff <= wb0 & 8'h3F;
      if (w_tcs)
        tcs_ff[5:0] <= wb0[5:0];
      tcs_ff[mps_pkg::TCS_COMPARE_CLEAR_IRQ_FLAG] <= nxt_compare_clear_irq_flag;
    end
  end

  // Output data, buffers, timer and position arming.
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      odr_ff    <= mps_pkg::RST_WORD;
      cpc_ff    <= 16'hFFFF;
      tmb_ff    <= mps_pkg::RST_WORD;
      cnt_ff    <= mps_pkg::RST_WORD;
      pre_ff    <= 7'h00;
      armed_ff  <= 1'b1;
      timer_count_enable_d_ff <= 1'b0;
      pwm_d_ff  <= 1'b0;
      pd_arm_ff <= 1'b0;
    end
    else
    begin
      pwm_d_ff  <= pwm_level;
      timer_count_enable_d_ff <= timer_count_enable;
      pd_arm_ff <= m_pdu & (pd_evt | (pd_arm_ff & ~xfer_go));
      if (xfer_go)
        odr_ff <= m_buf0 ? {odr_ff[15:8], src_val[7:0]}
                         : {odr_ff[15:11], odr_ff[10:8] + 3'h1,
                            src_val[7:0]};
      else if (w_odr)
      begin
        if (pstrb[1])
          odr_ff[15:8] <= pwdata[15:8];
        if (pstrb[0])
          odr_ff[7:0] <= pwdata[7:0];
      end
      if (w_cpc)
        cpc_ff <= pwdata[15:0];
      // A load equal to the count waits for the next arrival.
      armed_ff <= cpc_eq ? 1'b0 : (cnt_ff != cpc_ff) | armed_ff;
      if (timer_count_enable & ~timer_count_enable_d_ff)
        tmb_ff <= cnt_ff;
      pre_ff <= !timer_count_enable || tick ? 7'h00 : pre_ff + 7'h01;
      if (t_clr && (tick || tclr || !timer_count_enable))
        cnt_ff <= mps_pkg::RST_WORD;
      else if (tick)
        cnt_ff <= cnt_ff + 16'h0001;
    end
  end

  always_ff @(posedge clk)
  begin
    if (w_buf)
    begin
      if (pstrb[1])
        buf_mem[buf_idx][15:8] <= pwdata[15:8];
      if (pstrb[0])
        buf_mem[buf_idx][7:0] <= pwdata[7:0];
    end
  end

  // Bus answer, pin ownership, outputs and the shared interrupt.
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      ready_ff <= 1'b0;
      err_ff   <= 1'b0;
      rdata_ff <= 32'h0;
      wave_ff  <= 6'h00;
      irq_ff   <= 1'b0;
      owner_ff <= 1'b0;
      pwmf_ff  <= 1'b1;
      relf_ff  <= 1'b1;
    end
    else
    begin
      ready_ff <= psel & ~penable;
      err_ff   <= psel & ~penable & ~mapped;
      rdata_ff <= nxt_rdata;
      wave_ff  <= !seq_en ? 6'h00
                : (nxt_sd == mps_pkg::SD_TRIP && sd_en)
                  ? inl_ff[5:0]
                : odr_ff[5:0];
      irq_ff   <= nxt_shutdown_irq_flag | nxt_write_timing_irq_flag | nxt_position_detect_irq_flag | nxt_compare_match_irq_flag
                  | (nxt_compare_clear_irq_flag & nxt_compare_clear_irq_enable);
      owner_ff <= seq_en;
      pwmf_ff  <= ~seq_en;
      relf_ff  <= ~seq_en;
    end
  end

  assign prdata          = rdata_ff;
  assign pready          = ready_ff;
  assign pslverr         = err_ff;
  assign waveform_output = wave_ff;
  assign irq             = irq_ff;
  assign pin_owner       = owner_ff;
  assign pwm_free        = pwmf_ff;
  assign reload_free     = relf_ff;

  default clocking cb @(posedge clk); endclocking
  default disable iff (!arst_n);

  chk_sd_force_out: assert property (
    (nxt_sd == mps_pkg::SD_TRIP && sd_en && seq_en)
      |=> waveform_output == $past(inl_ff[5:0]))
    else $error("outputs not forced after shutdown");
  chk_sd_flag_set: assert property (
    (sd_trip && sd_en) |=> flg.shutdown_irq_flag)
    else $error("shutdown flag not raised");
  chk_irq_hold_any: assert property (
    (flg.shutdown_irq_flag || flg.write_timing_irq_flag || flg.position_detect_irq_flag || flg.compare_match_irq_flag) |-> irq)
    else $error("interrupt dropped while flag set");
  chk_compare_clear_irq_flag_irq_hold: assert property (
    (flg.compare_clear_irq_flag && tcs_ff[mps_pkg::TCS_COMPARE_CLEAR_IRQ_ENABLE]) |-> irq)
    else $error("compare clear interrupt dropped");
  chk_match_clears: assert property (
    cmp_hit |=> cnt_ff == 16'h0000 && flg.compare_clear_irq_flag)
    else $error("match did not clear timer");
  chk_equal_no_match: assert property (
    cpc_eq |=> !cmp_hit)
    else $error("match on equal compare load");
  chk_byte_no_start: assert property (
    (m_buf0 && buf0_wr && pstrb != mps_pkg::STRB_WORD) |-> !xfer_go)
    else $error("byte write started a transfer");
  chk_buf0_source: assert property (
    (xfer_go && m_buf0) |=> odr_ff[7:0] == $past(pwdata[7:0]))
    else $error("wrong source in buffer-zero method");
  chk_pin_owned: assert property (
    seq_en |=> pin_owner && !pwm_free && !reload_free)
    else $error("sequencer does not own pins");

  cov_shutdown: cover property (
    sd_trip && sd_en ##1 waveform_output == inl_ff[5:0]);
  cov_edge_xfer: cover property (pwm_edge && xfer_go);
  cov_buf0_xfer: cover property (xfer_go && m_buf0);
  cov_cmp_clear: cover property (cmp_hit ##1 irq);
endmodule

//--- test/mps_far_model.sv
`timescale 1ns/1ns
module mps_far_model (
  input  wire logic       clk,
  output logic            shutdown_input,
  output logic      [2:0] position_sense_input,
  output logic            pwm_level,
  output logic            reload_underflow
);
  logic [2:0] pwm_cnt_ff;
  initial
  begin
    shutdown_input = 1'b1;
    position_sense_input = 3'h0;
    pwm_level = 1'b0;
    reload_underflow = 1'b0;
    pwm_cnt_ff = 3'h0;
  end
  // The PWM level runs free with a period of ten cycles.
  always @(posedge clk)
  begin
    pwm_cnt_ff <= (pwm_cnt_ff == 3'h4) ? 3'h0 : pwm_cnt_ff + 3'h1;
    if (pwm_cnt_ff == 3'h4)
      pwm_level <= ~pwm_level;
  end
  // A reload timer in reload mode underflows as a one-cycle pulse.
  task automatic ufl_pulse();
    @(posedge clk);
    reload_underflow <= 1'b1;
    @(posedge clk);
    reload_underflow <= 1'b0;
  endtask
  // Sense levels are held well beyond two cycles.
  task automatic sense_step(input logic [2:0] v);
    @(posedge clk);
    position_sense_input <= v;
    repeat (12) @(posedge clk);
  endtask
  task automatic sd_level(input logic lvl, input int hold);
    @(posedge clk);
    shutdown_input <= lvl;
    repeat (hold) @(posedge clk);
  endtask
endmodule

//--- test/mps_sequencer_tb.sv
`timescale 1ns/1ns
module mps_sequencer_tb;
  logic        clk = 1'b0;
  logic        arst_n = 1'b0;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [15:0] paddr = 16'h0000;
  logic [31:0] pwdata = 32'h0;
  logic [3:0]  pstrb = 4'h0;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        shutdown_input;
  logic [2:0]  position_sense_input;
  logic        pwm_level;
  logic        reload_underflow;
  logic [5:0]  waveform_output;
  logic        irq;
  logic        pin_owner;
  logic        pwm_free;
  logic        reload_free;
  logic [31:0] rd_data;
  logic        rd_err;
  int          fails = 0;
  int          samples_checked = 0;
  int          n;
  int          lim;
  logic [5:0]  pats [4] = '{6'h15, 6'h2A, 6'h07, 6'h38};
  always #10 clk = ~clk;
  mps_sequencer mps_sequencer_i (
    .clk(clk), .arst_n(arst_n), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .shutdown_input(shutdown_input),
    .position_sense_input(position_sense_input),
    .pwm_level(pwm_level), .reload_underflow(reload_underflow),
    .waveform_output(waveform_output), .irq(irq),
    .pin_owner(pin_owner), .pwm_free(pwm_free),
    .reload_free(reload_free)
  );
  mps_far_model mps_far_model_i (
    .clk(clk), .shutdown_input(shutdown_input),
    .position_sense_input(position_sense_input),
    .pwm_level(pwm_level), .reload_underflow(reload_underflow)
  );
  task automatic apb(input logic [13:0] i, input logic w,
                     input logic [31:0] d, input logic [3:0] s);
    int k;
    k = 0;
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= {i, 2'b00};
    pwdata <= d;
    pstrb <= s;
    @(posedge clk);
    penable <= 1'b1;
    do
    begin
      @(posedge clk);
      k++;
    end
    while (pready !== 1'b1 && k < 20);
    rd_data = prdata;
    rd_err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (k >= 20)
      fails++;
  endtask
  task automatic wr(input logic [13:0] i, input logic [15:0] d,
                    input logic [3:0] s = mps_pkg::STRB_WORD);
    apb(i, 1'b1, {16'h0000, d}, s);
  endtask
  task automatic rd(input logic [13:0] i);
    apb(i, 1'b0, 32'h0, 4'h0);
  endtask
  task automatic chk(input string nm, input logic [31:0] got,
                     input logic [31:0] exp);
    samples_checked++;
    if (got !== exp)
    begin
      fails++;
      $display("BAD %s exp %h got %h", nm, exp, got);
    end
  endtask
  task automatic wait_irq(input int m);
    n = 0;
    while (irq !== 1'b1 && n < m)
    begin
      @(posedge clk);
      n++;
    end
  endtask
  task automatic odr_is(input logic [2:0] a, input logic [5:0] p);
    rd(mps_pkg::IDX_ODR);
    chk("odr", {rd_data[10:8], rd_data[5:0]}, {a, p});
  endtask
  task automatic clr_flags();
    wr(mps_pkg::IDX_OCU, 16'h0001);
    wr(mps_pkg::IDX_OCL, 16'h0002);
    wr(mps_pkg::IDX_ICU, 16'h0000);
  endtask
  task automatic results();
    $display("checks %0d fails %0d", samples_checked, fails);
    if (fails == 0 && samples_checked > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  initial
  begin
    repeat (20000) @(posedge clk);
    fails++;
    $display("watchdog expired");
    results();
  end
  initial
  begin
    repeat (8) @(posedge clk);
    arst_n <= 1'b1;
    chk("irq rst", irq, 1'b0);
    chk("free rst", {pwm_free, reload_free, pin_owner}, 3'h6);
    rd(mps_pkg::IDX_OCU);
    chk("ocu rst", rd_data, 32'h0);
    rd(mps_pkg::IDX_ICU);
    chk("icu rst", rd_data, 32'h0);
    rd(mps_pkg::IDX_NCC);
    chk("ncc rst", rd_data, 32'h0);
    rd(mps_pkg::IDX_CPC);
    chk("cpc rst", rd_data, 32'h0000FFFF);
    rd(14'h0070);
    chk("unmapped", {rd_err, rd_data}, {1'b1, 32'h0});
    wr(mps_pkg::IDX_OCU, 16'h0080);
    rd(mps_pkg::IDX_OCU);
    chk("ocu ro", rd_data, 32'h0);
    $display("test reset done");
    wr(mps_pkg::IDX_BUF0 + 14'h000B, 16'h003F);
    wr(mps_pkg::IDX_ODR, 16'h0B00);
    wr(mps_pkg::IDX_BUF0, 16'h0015, 4'h1);
    rd(mps_pkg::IDX_ODR);
    chk("byte lo", rd_data[5:0], 6'h00);
    wr(mps_pkg::IDX_BUF0, 16'h1500, 4'h2);
    rd(mps_pkg::IDX_ODR);
    chk("byte hi", rd_data[5:0], 6'h00);
    wr(mps_pkg::IDX_BUF0, 16'h0025);
    rd(mps_pkg::IDX_ODR);
    chk("word", rd_data[5:0], 6'h25);
    $display("test buffer zero done");
    wr(mps_pkg::IDX_OCL, 16'h0002);
    repeat (2) @(posedge clk);
    chk("own", {pwm_free, reload_free, pin_owner}, 3'h1);
    for (int k = 0; k < 4; k++)
      wr(mps_pkg::IDX_BUF0 + 14'(k + 1), {10'h000, pats[k]});
    wr(mps_pkg::IDX_ODR, 16'h0100);
    wr(mps_pkg::IDX_OCU, 16'h0020);
    mps_far_model_i.ufl_pulse();
    odr_is(3'h2, 6'h15);
    mps_far_model_i.ufl_pulse();
    odr_is(3'h3, 6'h2A);
    wr(mps_pkg::IDX_NCC, 16'h0004);
    wr(mps_pkg::IDX_ICL, 16'h0001);
    for (int k = 0; k < 2; k++)
    begin
      wr(mps_pkg::IDX_OCU, k ? 16'h0070 : 16'h0030);
      mps_far_model_i.ufl_pulse();
      odr_is(3'(3 + k), pats[1 + k]);
      mps_far_model_i.sense_step(k ? 3'h3 : 3'h1);
      mps_far_model_i.ufl_pulse();
      odr_is(3'(4 + k), pats[2 + k]);
    end
    wr(mps_pkg::IDX_ICL, 16'h0000);
    $display("test transfer done");
    clr_flags();
    wr(mps_pkg::IDX_INL, 16'h002A);
    mps_far_model_i.sd_level(1'b0, 0);
    n = 0;
    while (waveform_output !== 6'h2A && n < 10)
    begin
      @(posedge clk);
      n++;
    end
    chk("force time", n <= 6, 1'b1);
    rd(mps_pkg::IDX_OCU);
    chk("sd flags", rd_data[7:0] & 8'h84, 8'h84);
    chk("sd irq", irq, 1'b1);
    mps_far_model_i.sd_level(1'b1, 4);
    rd(mps_pkg::IDX_OCU);
    chk("sd sticky", rd_data[2], 1'b1);
    clr_flags();
    repeat (2) @(posedge clk);
    chk("irq clr", irq, 1'b0);
    for (int w = 0; w < 4; w++)
    begin
      lim = 4 << w;
      wr(mps_pkg::IDX_OCU, 16'h0001);
      wr(mps_pkg::IDX_NCC, 16'(w));
      wr(mps_pkg::IDX_OCU, 16'h0009);
      mps_far_model_i.sd_level(1'b0, lim - 3);
      mps_far_model_i.sd_level(1'b1, 10);
      chk("short", irq, 1'b0);
      mps_far_model_i.sd_level(1'b0, 0);
      wait_irq(lim + 12);
      chk("filter", n >= lim && n <= lim + 10, 1'b1);
      mps_far_model_i.sd_level(1'b1, 4);
      clr_flags();
    end
    $display("test shutdown done");
    wr(mps_pkg::IDX_CPC, 16'h000A);
    wr(mps_pkg::IDX_TCS, 16'h0021);
    wait_irq(40);
    chk("match time", n >= 8 && n <= 14, 1'b1);
    rd(mps_pkg::IDX_TCS);
    chk("compare_clear_irq_flag", rd_data[6], 1'b1);
    wr(mps_pkg::IDX_TCS, 16'h0020);
    wr(mps_pkg::IDX_ICU, 16'h0000);
    repeat (3) @(posedge clk);
    chk("cmp clr", irq, 1'b0);
    wr(mps_pkg::IDX_TCS, 16'h0001);
    repeat (30) @(posedge clk);
    wr(mps_pkg::IDX_TCS, 16'h0040);
    wr(mps_pkg::IDX_ICU, 16'h0000);
    repeat (2) @(posedge clk);
    chk("no compare_clear_irq_enable", irq, 1'b0);
    rd(mps_pkg::IDX_TCS);
    chk("iclr2", rd_data[6], 1'b1);
    wr(mps_pkg::IDX_TCS, 16'h0080);
    wr(mps_pkg::IDX_CPC, 16'h0000);
    wr(mps_pkg::IDX_TCS, 16'h0001);
    repeat (10) @(posedge clk);
    rd(mps_pkg::IDX_TCS);
    chk("eq load", rd_data[6], 1'b0);
    wr(mps_pkg::IDX_TCS, 16'h0000);
    $display("test timer done");
    wr(mps_pkg::IDX_ODR, 16'h0101);
    wr(mps_pkg::IDX_OCU, 16'h0010);
    for (int e = 1; e < 3; e++)
    begin
      wr(mps_pkg::IDX_ICU, 16'(e));
      wait_irq(15);
      chk("edge lvl", pwm_level, e == 1);
      wr(mps_pkg::IDX_ICU, 16'h0000);
      odr_is(3'(e + 1), pats[e - 1]);
      wr(mps_pkg::IDX_OCU, 16'h0010);
    end
    $display("test edge done");
    results();
  end
endmodule
